// ==== design/machine_cycle_sequencer.sv ====
// Machine cycle sequencer: state timing, code fetch scheduling, data access window
`timescale 1ns/1ns
module machine_cycle_sequencer (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // Oscillator pin
  input  wire logic                 osc_amp_input,
  // Code bus
  input  wire logic [7:0]           code_byte,
  // Decoder report for the opcode in the instruction register
  input  wire mcs_pkg::instr_info_t instr_info,
  // Timing outputs
  output mcs_pkg::slot_t            slot,
  output logic                      alu_phase,
  output logic                      move_phase,
  // Fetch control
  output logic                      code_read,
  output logic                      pc_advance,
  output logic                      addr_latch_strobe,
  output logic [7:0]                instr_reg,
  output logic [7:0]                operand_reg,
  output logic                      opcode_load,
  output logic                      operand_load,
  output logic                      instr_done,
  // Data memory access
  output logic                      xdata_active,
  output logic                      ext_bus_enable,
  output logic                      int_ram_enable
);
  logic osc_tick;
  logic cycle_end;

  osc_divider osc_divider_inst (
    .sys_clk       (sys_clk),
    .reset_n       (reset_n),
    .osc_amp_input (osc_amp_input),
    .osc_tick      (osc_tick)
  );

  slot_counter slot_counter_inst (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .osc_tick  (osc_tick),
    .slot      (slot),
    .cycle_end (cycle_end)
  );

  typedef enum logic [2:0] {
    FIRST  = 3'b001,
    MIDDLE = 3'b010,
    LAST   = 3'b100
  } cyc_t;

  typedef struct packed {
    cyc_t        cyc;
    logic [1:0]  cycles_left;
    logic [1:0]  bytes_left;
    logic [7:0]  ir;
    logic [7:0]  opnd;
    logic        op_load;
    logic        opnd_load;
    logic        pc_adv;
    logic        done;
    logic        xdata;
    logic        ext;
    logic        rd;
    logic        ale;
  } seq_state_t;

  seq_state_t cur;
  seq_state_t next_cur;
  logic       at_fetch_a;
  logic       at_fetch_b;
  logic       slot_p1;

  always_comb begin
    slot_p1    = osc_tick & ~slot.phase2;
    at_fetch_a = slot_p1 & (slot.state == mcs_pkg::FETCH_STATE_A);
    at_fetch_b = slot_p1 & (slot.state == mcs_pkg::FETCH_STATE_B);
  end

  always_comb begin
    next_cur           = cur;
    next_cur.op_load   = 1'b0;
    next_cur.opnd_load = 1'b0;
    next_cur.pc_adv    = 1'b0;
    next_cur.done      = 1'b0;
    next_cur.rd        = 1'b0;
    next_cur.ale       = 1'b0;
    // Two code reads per cycle, suppressed in the second cycle of a data move
    if ((at_fetch_a || at_fetch_b) && !(cur.xdata && cur.cyc != FIRST)) begin
      next_cur.rd  = 1'b1;
      next_cur.ale = 1'b1;
    end
    // Opcode fetch at state one of a new instruction; latched in phase two
    if (osc_tick && slot.phase2 && slot.state == mcs_pkg::FETCH_STATE_A && cur.cyc == FIRST
        && cur.cycles_left == 2'h0 && cur.bytes_left == 2'h0) begin
      next_cur.ir      = code_byte;
      next_cur.op_load = 1'b1;
      next_cur.pc_adv  = 1'b1;
    end
    // Decoder answer arrives the cycle after the load
    if (cur.op_load) begin
      next_cur.bytes_left  = 2'(instr_info.nbytes - 2'h1);
      next_cur.cycles_left = instr_info.ncycles;
      next_cur.xdata       = instr_info.is_xdata;
      next_cur.ext         = instr_info.xdata_ext;
    end
    // State four byte: operand if one is owed, else discarded without PC advance
    if (at_fetch_b && cur.bytes_left != 2'h0 && !cur.xdata) begin
      next_cur.opnd       = code_byte;
      next_cur.opnd_load  = 1'b1;
      next_cur.pc_adv     = 1'b1;
      next_cur.bytes_left = 2'(cur.bytes_left - 2'h1);
    end
    // Later cycles' state one fetch takes a third byte if owed; otherwise it is a discarded next opcode
    if (at_fetch_a && cur.cyc != FIRST && cur.bytes_left != 2'h0 && !cur.xdata) begin
      next_cur.opnd       = code_byte;
      next_cur.opnd_load  = 1'b1;
      next_cur.pc_adv     = 1'b1;
      next_cur.bytes_left = 2'(cur.bytes_left - 2'h1);
    end
    if (cycle_end) begin
      if (cur.cycles_left == 2'h0) begin
        next_cur.done  = 1'b1;
        next_cur.cyc   = FIRST;
        next_cur.xdata = 1'b0;
        next_cur.bytes_left = 2'h0;
      end else begin
        next_cur.cycles_left = 2'(cur.cycles_left - 2'h1);
        next_cur.cyc = (cur.cycles_left == 2'h1) ? LAST : MIDDLE;
      end
    end
    // Data window closes after state three of the second cycle
    if (cur.xdata && cur.cyc != FIRST && osc_tick && slot.phase2 && slot.state == mcs_pkg::XDATA_END) begin
      next_cur.ext = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '{cyc: FIRST, cycles_left: mcs_pkg::RESET_CYCLES_LEFT, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  logic in_window;
  always_comb begin
    // State four onward of cycle one, through state three of cycle two
    in_window = cur.xdata && ((cur.cyc == FIRST && slot.state >= mcs_pkg::XDATA_START && !cur.op_load)
                || (cur.cyc != FIRST && slot.state <= mcs_pkg::XDATA_END));
  end

  assign alu_phase         = ~slot.phase2;
  assign move_phase        = slot.phase2;
  assign code_read         = cur.rd;
  assign addr_latch_strobe = cur.ale;
  assign pc_advance        = cur.pc_adv;
  assign instr_reg         = cur.ir;
  assign operand_reg       = cur.opnd;
  assign opcode_load       = cur.op_load;
  assign operand_load      = cur.opnd_load;
  assign instr_done        = cur.done;
  assign xdata_active      = in_window;
  assign ext_bus_enable    = in_window & cur.ext;
  assign int_ram_enable    = in_window & ~cur.ext;

  // Assertions
  phase_split_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    alu_phase != move_phase) else $error("phase one and two overlap");
  fetch_slot_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    code_read |-> $past(slot.state) == 3'h1 || $past(slot.state) == 3'h4) else $error("code read outside S1/S4");
  ale_pairs_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    addr_latch_strobe == code_read) else $error("latch strobe not paired with fetch");
  opcode_latch_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    opcode_load |-> $past(slot.state) == 3'h1 && $past(slot.phase2)) else $error("opcode not at S1P2");
  done_end_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    instr_done |-> slot.state == 3'h1 && !slot.phase2) else $error("completion not at STATE6_PHASE2 end");
  ports_alone_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(ext_bus_enable && int_ram_enable)) else $error("both data buses enabled");
  window_edges_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    xdata_active != $past(xdata_active) |-> slot.state == mcs_pkg::XDATA_START && !slot.phase2)
    else $error("data window edge not at state four");
  no_read_c2_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cur.xdata && cur.cyc != FIRST |-> !code_read) else $error("code read in data move cycle two");
  operand_pc_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    operand_load |-> pc_advance) else $error("operand without PC advance");
endmodule // machine_cycle_sequencer

// ==== design/mcs_pkg.sv ====
// Package: timing constants, fetch/access types for the machine cycle sequencer
package mcs_pkg;
  localparam int STATES_PER_CYCLE = 6;
  localparam int PHASES_PER_STATE = 2;
  localparam int OSC_PER_CYCLE    = 12;
  localparam logic [2:0] FETCH_STATE_A = 3'h1;
  localparam logic [2:0] FETCH_STATE_B = 3'h4;
  localparam logic [2:0] XDATA_START   = 3'h4;
  localparam logic [2:0] XDATA_END     = 3'h3;
  localparam logic [2:0] LAST_STATE    = 3'h6;
  localparam logic [1:0] RESET_CYCLES_LEFT = 2'h0;

  // Instruction length and duration as the decoder reports them
  typedef struct packed {
    logic [1:0] nbytes;     // 1..3
    logic [1:0] ncycles;    // 0 = one, 1 = two, 3 = four
    logic       is_xdata;
    logic       xdata_ext;  // Target mapped on the expanded bus
  } instr_info_t;

  typedef struct packed {
    logic [2:0] state;      // 1..6
    logic       phase2;
  } slot_t;
endpackage

// ==== design/osc_divider.sv ====
// Rising-edge detector turning the oscillator input into one tick per period
`timescale 1ns/1ns
module osc_divider (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Oscillator input, asynchronous
  input  wire logic osc_amp_input,
  // One pulse per oscillator period
  output logic      osc_tick
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic tick;
  } div_state_t;

  div_state_t cur;
  div_state_t next_cur;

  always_comb begin
    next_cur      = cur;
    next_cur.s1   = osc_amp_input;
    next_cur.s2   = cur.s1;
    next_cur.prev = cur.s2;
    // Rising edges only, so duty cycle does not matter
    next_cur.tick = cur.s2 & ~cur.prev;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      // History starts high so a pin already high at release gives no false edge
      cur <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, tick: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign osc_tick = cur.tick;

  tick_one_cycle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    osc_tick |=> !osc_tick) else $error("oscillator tick longer than one cycle");
endmodule // osc_divider

// ==== design/slot_counter.sv ====
// Steps through the twelve state/phase slots of a machine cycle
`timescale 1ns/1ns
module slot_counter (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  // Advance strobe
  input  wire logic          osc_tick,
  // Current slot
  output mcs_pkg::slot_t     slot,
  output logic               cycle_end
);
  mcs_pkg::slot_t next_slot;

  always_comb begin
    next_slot = slot;
    if (osc_tick) begin
      if (!slot.phase2) begin
        next_slot.phase2 = 1'b1;
      end else begin
        next_slot.phase2 = 1'b0;
        next_slot.state  = (slot.state == mcs_pkg::LAST_STATE) ? 3'h1 : 3'(slot.state + 3'h1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      slot <= '{state: 3'h1, phase2: 1'b0};
    end else begin
      slot <= next_slot;
    end
  end

  assign cycle_end = osc_tick & slot.phase2 & (slot.state == mcs_pkg::LAST_STATE);

  state_range_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    slot.state >= 3'h1 && slot.state <= 3'h6) else $error("state out of range");
  phase_order_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    osc_tick && slot.phase2 && slot.state != 3'h6 |=> slot.state == $past(slot.state) + 3'h1 && !slot.phase2)
    else $error("state did not advance after phase two");
  wrap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cycle_end |=> slot.state == 3'h1 && !slot.phase2) else $error("no wrap to state one");
endmodule // slot_counter

// ==== sim/decoder_model.sv ====
// Decoder and code memory model facing the sequencer
`timescale 1ns/1ns
module decoder_model (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            reset_n,
  // Fetch side
  input  wire logic            pc_advance,
  input  wire logic            opcode_load,
  output logic [7:0]           code_byte,
  output mcs_pkg::instr_info_t instr_info
);
  logic [7:0] mem [0:127];
  logic [7:0] ops [0:63];
  int         pc;
  int         idx;

  // Opcode bits 1:0 length, 3:2 cycle code, 4 data move, 5 expanded bus
  function automatic mcs_pkg::instr_info_t dec(input logic [7:0] op);
    return '{op[1:0], op[3:2], op[4], op[5]};
  endfunction

  // Report follows the opcode being loaded, then the one held
  assign code_byte  = mem[pc[6:0]];
  assign instr_info = dec(ops[opcode_load ? idx + 1 : (idx < 0 ? 0 : idx)]);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc  <= 0;
      idx <= -1;
    end else begin
      if (pc_advance) pc <= pc + 1;
      if (opcode_load) idx <= idx + 1;
    end
  end
endmodule // decoder_model

// ==== sim/tb_top.sv ====
// Self-checking bench for the machine cycle sequencer
`timescale 1ns/1ns
module tb_top;
  logic sys_clk, reset_n, osc_amp_input = 1'b0;
  logic [7:0] code_byte, instr_reg, operand_reg;
  mcs_pkg::instr_info_t instr_info;
  mcs_pkg::slot_t slot, ps;
  logic alu_phase, move_phase, code_read, pc_advance, addr_latch_strobe;
  logic opcode_load, operand_load, instr_done, xdata_active, ext_bus_enable, int_ram_enable, pxa;
  int seed = 92668;
  int bad_count, total_checks, rises, tot, chg, ncyc, rdn, alen, cnt, dn;
  bit started, xd;
  logic [7:0] opq[$], opndq[$];
  int cycq[$];
  // Three-byte kinds need two cycles: only two code reads fit in one
  logic [7:0] kinds [0:7] = '{8'h01, 8'h02, 8'h07, 8'h05, 8'h06, 8'h0D, 8'h15, 8'h35};

  machine_cycle_sequencer machine_cycle_sequencer_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .osc_amp_input(osc_amp_input), .code_byte(code_byte), .instr_info(instr_info), .slot(slot),
    .alu_phase(alu_phase), .move_phase(move_phase), .code_read(code_read), .pc_advance(pc_advance),
    .addr_latch_strobe(addr_latch_strobe), .instr_reg(instr_reg), .operand_reg(operand_reg),
    .opcode_load(opcode_load), .operand_load(operand_load), .instr_done(instr_done),
    .xdata_active(xdata_active), .ext_bus_enable(ext_bus_enable), .int_ram_enable(int_ram_enable));
  decoder_model decoder_model_inst (.sys_clk(sys_clk), .reset_n(reset_n), .pc_advance(pc_advance),
    .opcode_load(opcode_load), .code_byte(code_byte), .instr_info(instr_info));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Counts: %0d checks, %0d mismatches", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    sys_clk = 0;
    forever #5 sys_clk = !sys_clk;
  end

  // Random half periods of 3..5 clocks keep the oscillator period legal
  always @(posedge sys_clk) begin
    if (cnt == 0) begin
      osc_amp_input <= !osc_amp_input;
      cnt <= 2 + $unsigned($random(seed)) % 3;
      if (!osc_amp_input && reset_n) rises++;
    end else cnt <= cnt - 1;
  end

  // Monitor: sampled on the falling edge, where outputs have settled
  always @(negedge sys_clk) begin
    if (!reset_n) begin
      ps = slot;
      started = 0;
      chg = 0;
      ncyc = 0;
      pxa = 0;
    end else begin
      check(alu_phase, !slot.phase2, "alu_phase");
      check(move_phase, slot.phase2, "move_phase");
      if (slot !== ps) begin
        check(slot, ps.phase2 ? {(ps.state == 3'h6) ? 3'h1 : ps.state + 3'h1, 1'b0} : {ps.state, 1'b1}, "slot");
        chg++;
        tot++;
        if (slot === 4'h2) begin
          if (ncyc > 0 && !xd) begin
            check(rdn, 2, "code_reads");
            check(alen, 2, "ale_pulses");
          end
          ncyc++;
          rdn = 0;
          alen = 0;
          xd = 0;
        end
      end
      ps = slot;
      rdn += code_read;
      alen += addr_latch_strobe;
      dn += instr_done;
      if (xdata_active) begin
        xd = 1;
        check(ext_bus_enable, instr_info.xdata_ext, "ext_bus");
        check(int_ram_enable, !instr_info.xdata_ext, "int_ram");
      end else check({ext_bus_enable, int_ram_enable}, 0, "bus_idle");
      if (xdata_active !== pxa) check(slot, 4'h8, "window_edge");
      pxa = xdata_active;
      if (opcode_load) begin
        check(slot, 4'h4, "load_slot");
        if (started) check(dn, 1, "done_count");
        dn = 0;
        if (opq.size() > 0) check(instr_reg, opq.pop_front(), "opcode");
        if (started && cycq.size() > 0) check(chg, 12 * cycq.pop_front(), "cycle_len");
        started = 1;
        chg = 0;
      end
      if (operand_load && opndq.size() > 0) check(operand_reg, opndq.pop_front(), "operand");
      if (instr_done) check(slot, 4'h2, "done_slot");
    end
  end

  initial begin
    int p, k, i;
    logic [7:0] op, b;
    p = 0;
    reset_n = 0;
    // Every instruction kind once, then a random mix
    for (i = 0; i < 24; i++) begin
      k = (i < 8) ? i : $unsigned($random(seed)) % 8;
      op = {2'($random(seed)), kinds[k][5:0]};
      decoder_model_inst.ops[i] = op;
      decoder_model_inst.mem[p++] = op;
      opq.push_back(op);
      cycq.push_back(op[3:2] == 2'h3 ? 4 : op[3:2] + 1);
      for (int j = 1; j < op[1:0]; j++) begin
        b = 8'($random(seed));
        decoder_model_inst.mem[p++] = b;
        opndq.push_back(b);
      end
    end
    for (i = 24; i < 64; i++) decoder_model_inst.ops[i] = 8'h01;
    for (i = p; i < 128; i++) decoder_model_inst.mem[i] = 8'h01;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1;
    for (i = 0; i < 30000 && (opq.size() > 0 || opndq.size() > 0 || cycq.size() > 1); i++) @(posedge sys_clk);
    if (i == 30000) begin
      // Timeout counts as a mismatch
      bad_count++;
    end else begin
      check((rises - tot) inside {0, 1}, 1, "divider");
      $display("Test program run finished");
      cycq.delete();
      @(posedge sys_clk);
      reset_n <= 0;
      repeat (3) @(posedge sys_clk);
      check({slot, instr_reg, code_read}, 0 | 13'h0400, "reset_state");
      reset_n <= 1;
      repeat (200) @(posedge sys_clk);
      $display("Test mid-run reset finished");
    end
    end_of_test();
  end
endmodule // tb_top
